// [design/true_dual_port_block_ram.sv]
// true dual-port memory with two symmetric ports and an AHB-Lite config slave
// Notes on behaviour
// - one shared array, two symmetric ports
// - each port own address, data, enable, write
// - enable low: no write, latch output holds
// - sync preset forces output to initial value
// - cascade pairs for latch and register output
// - latch mode read takes one edge
// - output register adds one cycle latency
// - write completes on a single edge
// - per-port write mode, write-through default
// - write-through shows newly written word
// - read-first shows old word while writing
// - hold mode keeps last read output
// - simultaneous reads always allowed
// - read-first writer: other port reads old data
// - other writer modes: other port read unreliable
// - output register has own enable, holds
// - write width selectable apart from read width
// - write-through shows new enabled, old other bytes
// - parity bits stored like data bits
// - output keeps value until next operation
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "tdp_ram_map.svh"
module true_dual_port_block_ram
  import tdp_ram_pkg::*;
#(
  parameter int ADDR_W = 10,
  parameter logic [35:0] INIT_A = `TDP_INIT_WORD,
  parameter logic [35:0] INIT_B = `TDP_INIT_WORD
) (
  input wire logic mclk,
  input wire logic rst,
  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // ----------------------------------------------------------------------
  // port A
  // ----------------------------------------------------------------------
  input wire logic enA,
  input wire logic [3:0] writeEnA,
  input wire logic [ADDR_W-1:0] addrA,
  input wire logic [31:0] port_input_word_a,
  input wire logic [3:0] port_input_parity_a,
  input wire logic port_sync_preset_a,
  input wire logic output_stage_clock_enable_a,
  input wire logic chain_in_unregistered_a,
  input wire logic chain_in_registered_a,
  output logic [31:0] dataOutA,
  output logic [3:0] port_output_parity_a,
  output logic chain_out_unregistered_a,
  output logic chain_out_registered_a,
  // ----------------------------------------------------------------------
  // port B
  // ----------------------------------------------------------------------
  input wire logic enB,
  input wire logic [3:0] writeEnB,
  input wire logic [ADDR_W-1:0] addrB,
  input wire logic [31:0] port_input_word_b,
  input wire logic [3:0] port_input_parity_b,
  input wire logic port_sync_preset_b,
  input wire logic output_stage_clock_enable_b,
  input wire logic chain_in_unregistered_b,
  input wire logic chain_in_registered_b,
  output logic [31:0] dataOutB,
  output logic [3:0] port_output_parity_b,
  output logic chain_out_unregistered_b,
  output logic chain_out_registered_b
);
  localparam int DEPTH = 1 << ADDR_W;
  // ----------------------------------------------------------------------
  // storage and per-port views
  // ----------------------------------------------------------------------
  // word layout: parity nibble above the four data bytes, lane k owns byte k and parity k
  logic [35:0] mem [0:DEPTH-1];
  logic [1:0] pEn; // port enables
  logic [1:0] pPre; // sync presets
  logic [1:0] pCe; // output stage enables
  logic [1:0] pRegEn; // output register selected
  logic [1:0] pCasc; // cascade bit0 taken from chain input
  logic [1:0] pChainU; // chain inputs, latch path
  logic [1:0] pChainR; // chain inputs, register path
  logic [3:0] pWe [2]; // byte write enables
  logic [ADDR_W-1:0] pAddr [2];
  logic [35:0] pWord [2]; // merged data plus parity input
  logic [35:0] pInit [2];
  wmode_t pMode [2];
  logic [35:0] rdWord [2]; // current array word at each port address
  logic [35:0] mrgWord [2]; // stored word with enabled bytes replaced
  logic [35:0] latch_reg [2]; // first output stage
  logic [35:0] latch_next [2];
  logic [35:0] pipe_reg [2]; // optional output register
  logic [35:0] pipe_next [2];
  logic [35:0] out_reg [2]; // drives the data pins
  logic [35:0] out_next [2];
  logic [`TDP_CFG_W-1:0] cfg_reg; // steers modes and output stage
  logic collide_reg; // sticky same-address hazard seen
  logic collide_next;
  logic sameAddrHit;
  // AHB-Lite slave state
  logic wrPend_reg;
  logic [11:0] wrAddr_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rdMux;
  logic addrPhase;

  // gather the separate pins into indexed views for the shared port logic
  assign pEn = {enB, enA};
  assign pPre = {port_sync_preset_b, port_sync_preset_a};
  assign pCe = {output_stage_clock_enable_b, output_stage_clock_enable_a};
  assign pRegEn = {cfg_reg[`TDP_REGEN_B_BIT], cfg_reg[`TDP_REGEN_A_BIT]};
  assign pCasc = {cfg_reg[`TDP_CASC_B_BIT], cfg_reg[`TDP_CASC_A_BIT]};
  assign pChainU = {chain_in_unregistered_b, chain_in_unregistered_a};
  assign pChainR = {chain_in_registered_b, chain_in_registered_a};
  assign pWe[0] = writeEnA;
  assign pWe[1] = writeEnB;
  assign pAddr[0] = addrA;
  assign pAddr[1] = addrB;
  assign pWord[0] = {port_input_parity_a, port_input_word_a};
  assign pWord[1] = {port_input_parity_b, port_input_word_b};
  assign pInit[0] = INIT_A;
  assign pInit[1] = INIT_B;
  assign pMode[0] = wmode_t'(cfg_reg[`TDP_MODE_A_LSB +: 2]);
  assign pMode[1] = wmode_t'(cfg_reg[`TDP_MODE_B_LSB +: 2]);

  // ----------------------------------------------------------------------
  // per-port datapath
  // ----------------------------------------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_port
    // array read is free of any port priority, so both ports may read anything
    assign rdWord[p] = mem[pAddr[p]];
    // narrow writes via byte enables; unwritten lanes keep stored contents
    for (genvar k = 0; k < 4; k++) begin : g_lane
      assign mrgWord[p][8*k +: 8] = pWe[p][k] ? pWord[p][8*k +: 8] : rdWord[p][8*k +: 8];
      assign mrgWord[p][32+k] = pWe[p][k] ? pWord[p][32+k] : rdWord[p][32+k];
    end

    // latch stage: read, read-during-write choice, preset
    always_comb begin
      latch_next[p] = latch_reg[p];
      if (pEn[p]) begin
        if (pPre[p]) begin
          latch_next[p] = pInit[p];
        end else if (|pWe[p]) begin
          case (pMode[p])
            WM_READ_FIRST: latch_next[p] = rdWord[p];
            WM_HOLD: latch_next[p] = latch_reg[p];
            default: latch_next[p] = mrgWord[p];
          endcase
        end else begin
          latch_next[p] = rdWord[p];
        end
      end
    end

    // output register stage: own enable, independent of the array
    always_comb begin
      pipe_next[p] = pipe_reg[p];
      if (pCe[p]) begin
        pipe_next[p] = pPre[p] ? pInit[p] : latch_reg[p];
      end
    end

    // the pins are a third flop loaded with whichever stage is visible, so they
    // leave a flop yet keep the latch or register timing exactly
    always_comb begin
      out_next[p] = pRegEn[p] ? pipe_next[p] : latch_next[p];
      if (pCasc[p]) begin
        out_next[p][0] = pRegEn[p] ? pChainR[p] : pChainU[p];
      end
    end

    // latch flop; holds while the port is idle
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        latch_reg[p] <= `TDP_INIT_WORD;
      end else begin
        latch_reg[p] <= latch_next[p];
      end
    end

    // pipeline flop
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        pipe_reg[p] <= `TDP_INIT_WORD;
      end else begin
        pipe_reg[p] <= pipe_next[p];
      end
    end

    // pin flop
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        out_reg[p] <= `TDP_INIT_WORD;
      end else begin
        out_reg[p] <= out_next[p];
      end
    end

    // ------------------------------------------------------------------
    // checks for this port
    // ------------------------------------------------------------------
    sequence sReadIssue;
      pEn[p] && !(|pWe[p]) && !pPre[p];
    endsequence
    sequence sWriteIssue;
      pEn[p] && (|pWe[p]) && !pPre[p];
    endsequence

    a_idle_hold: assert property (@(posedge mclk) disable iff (rst)
      !pEn[p] |=> $stable(latch_reg[p]))
      else $error("port output moved while disabled");
    a_read_one_edge: assert property (@(posedge mclk) disable iff (rst)
      sReadIssue |=> latch_reg[p] == $past(rdWord[p]))
      else $error("latch read did not return stored word");
    a_reg_latency: assert property (@(posedge mclk) disable iff (rst)
      sReadIssue ##1 (pCe[p] && !pPre[p]) |=> pipe_reg[p] == $past(rdWord[p], 2))
      else $error("registered read not one cycle later");
    a_preset_init: assert property (@(posedge mclk) disable iff (rst)
      (pEn[p] && pPre[p]) |=> latch_reg[p] == pInit[p])
      else $error("preset did not load initial value");
    a_through_mix: assert property (@(posedge mclk) disable iff (rst)
      (sWriteIssue and pMode[p] == WM_THROUGH) |=> latch_reg[p] == $past(mrgWord[p]))
      else $error("write-through output wrong");
    a_first_old: assert property (@(posedge mclk) disable iff (rst)
      (sWriteIssue and pMode[p] == WM_READ_FIRST) |=> latch_reg[p] == $past(rdWord[p]))
      else $error("read-first output not old word");
    a_hold_write: assert property (@(posedge mclk) disable iff (rst)
      (sWriteIssue and pMode[p] == WM_HOLD) |=> $stable(latch_reg[p]))
      else $error("hold mode output changed on write");
    a_write_lands: assert property (@(posedge mclk) disable iff (rst)
      (sWriteIssue and !sameAddrHit) |=> mem[$past(pAddr[p])] == $past(mrgWord[p]))
      else $error("write not stored after one edge");
  end

  // ----------------------------------------------------------------------
  // array write
  // ----------------------------------------------------------------------
  // port B is applied last, so a same-cycle double write keeps B; the user
  // must not rely on that, the stored word is undefined by contract
  always_ff @(posedge mclk) begin
    for (int p = 0; p < 2; p++) begin
      if (pEn[p] && !pPre[p] && (|pWe[p])) begin
        mem[pAddr[p]] <= mrgWord[p];
      end
    end
  end

  // ----------------------------------------------------------------------
  // hazard monitor
  // ----------------------------------------------------------------------
  // both ports active on one address with a write involved; reads by the
  // other port get the old word, which is only promised in read-first mode
  assign sameAddrHit = pEn[0] && pEn[1] && (pAddr[0] == pAddr[1])
    && ((|pWe[0]) || (|pWe[1]));
  always_comb begin
    collide_next = collide_reg;
    if (wrPend_reg && wrAddr_reg == `TDP_STAT_OFS && hwdata[0]) begin
      collide_next = 1'b0;
    end
    if (sameAddrHit) begin
      collide_next = 1'b1; // set beats a same-cycle clear
    end
  end

  // sticky flag flop
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      collide_reg <= `TDP_STAT_RST;
    end else begin
      collide_reg <= collide_next;
    end
  end

  // ----------------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ----------------------------------------------------------------------
  assign addrPhase = hsel && htrans[1] && hready;

  // read value decoded during the address phase; unmapped reads give zero
  always_comb begin
    rdMux = 32'h00000000;
    case (haddr[11:0])
      `TDP_CFG_OFS: rdMux = {24'h000000, cfg_reg};
      `TDP_STAT_OFS: rdMux = {31'h00000000, collide_reg};
      default: rdMux = 32'h00000000;
    endcase
  end

  // address phase capture for writes, data phase read word
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 12'h000;
      hrdata_reg <= 32'h00000000;
    end else begin
      if (hready) begin
        wrPend_reg <= addrPhase && hwrite;
        wrAddr_reg <= haddr[11:0];
      end
      if (addrPhase && !hwrite) begin
        hrdata_reg <= rdMux;
      end
    end
  end

  // config write in the data phase; writes to unmapped words are dropped
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_reg <= `TDP_CFG_RST;
    end else if (wrPend_reg && wrAddr_reg == `TDP_CFG_OFS) begin
      cfg_reg <= hwdata[`TDP_CFG_W-1:0];
    end
  end

  // handshake flops: never stall, never error
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------------
  assign hrdata = hrdata_reg;
  assign dataOutA = out_reg[0][31:0];
  assign port_output_parity_a = out_reg[0][35:32];
  assign dataOutB = out_reg[1][31:0];
  assign port_output_parity_b = out_reg[1][35:32];
  assign chain_out_unregistered_a = latch_reg[0][0];
  assign chain_out_registered_a = pipe_reg[0][0];
  assign chain_out_unregistered_b = latch_reg[1][0];
  assign chain_out_registered_b = pipe_reg[1][0];

  a_sticky_set: assert property (@(posedge mclk) disable iff (rst)
    sameAddrHit |=> collide_reg)
    else $error("hazard flag not set");
endmodule

// [design/tdp_ram_map.svh]
// offsets, field positions, reset values and timing counts of the dual-port memory
`ifndef TDP_RAM_MAP_SVH
`define TDP_RAM_MAP_SVH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define TDP_CFG_OFS 12'h000
`define TDP_STAT_OFS 12'h004
// ----------------------------------------------------------------------
// config fields
// ----------------------------------------------------------------------
`define TDP_MODE_A_LSB 0
`define TDP_MODE_B_LSB 2
`define TDP_REGEN_A_BIT 4
`define TDP_REGEN_B_BIT 5
`define TDP_CASC_A_BIT 6
`define TDP_CASC_B_BIT 7
`define TDP_CFG_W 8
// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define TDP_CFG_RST 8'h00
`define TDP_STAT_RST 1'b0
`define TDP_INIT_WORD 36'h000000000
`define TDP_CLK_PERIOD_NS 10
`define TDP_READ_EDGES 1
`endif

// [design/tdp_ram_pkg.sv]
// types shared by the dual-port memory
package tdp_ram_pkg;
  // read-during-write behaviour of one port
  typedef enum logic [1:0] {
    WM_THROUGH,
    WM_READ_FIRST,
    WM_HOLD
  } wmode_t;
endpackage

// [tb/port_user_model.sv]
// user logic model driving one memory port
`timescale 1ns/1ps
module port_user_model #(
  parameter int ADDR_W = 10
) (
  input wire logic mclk,
  output logic en,
  output logic [3:0] writeEn,
  output logic [ADDR_W-1:0] addr,
  output logic [35:0] dataIn,
  output logic preset,
  output logic stageEn,
  output logic chainLat,
  output logic chainReg
);
  // ----------------------------------------------------------------------
  // idle levels at time zero
  // ----------------------------------------------------------------------
  initial begin
    en = 1'b0;
    writeEn = 4'h0;
    addr = '0;
    dataIn = 36'h0;
    preset = 1'b0;
    stageEn = 1'b0;
    chainLat = 1'b0;
    chainReg = 1'b0;
  end
  // ----------------------------------------------------------------------
  // one request per call, taken at the next edge, then withdrawn
  // ----------------------------------------------------------------------
  // callers never aim a write at a word the other port touches, bar read-first;
  // both ports share one clock, so there is no clock-to-clock window to keep
  task automatic op(input logic e, input logic [3:0] w, input logic [ADDR_W-1:0] a,
                    input logic [35:0] d, input logic s, input logic p);
    @(posedge mclk);
    en <= e;
    writeEn <= w;
    addr <= a;
    stageEn <= s;
    preset <= p;
    // disabled port: data lines wander so a stale value cannot pass for a write
    dataIn <= e ? d : ~dataIn;
    @(posedge mclk);
    // taken at this edge: withdraw it so the port does not repeat it, but
    // leave the output stage enable standing as a free-running user would
    en <= 1'b0;
    writeEn <= 4'h0;
    preset <= 1'b0;
    #1;
  endtask
  // cascade inputs, set on an edge and left standing
  task automatic chain(input logic l, input logic r);
    @(posedge mclk);
    chainLat <= l;
    chainReg <= r;
    #1;
  endtask
endmodule

// [tb/test_true_dual_port_block_ram.sv]
// self-checking bench for the dual-port memory
`timescale 1ns/1ps
`include "tdp_ram_map.svh"
module test_true_dual_port_block_ram;
  import tdp_ram_pkg::*;
  // ----------------------------------------------------------------------
  // clock, reset and bus signals
  // ----------------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata, rd;
  // port wires between models and memory
  logic enA, enB, preA, preB, oceA, oceB, clA, clB, crA, crB;
  logic [3:0] weA, weB;
  logic [9:0] adA, adB;
  logic [35:0] dA, dB;
  logic [31:0] qA, qB;
  logic [3:0] pA, pB;
  logic coLA, coRA, coLB, coRB;
  int err_count = 0;
  int tests_run = 0;
  always #5 mclk = ~mclk;
  // ----------------------------------------------------------------------
  // design and port partners
  // ----------------------------------------------------------------------
  // hready is the single slave's own hreadyout
  true_dual_port_block_ram i_true_dual_port_block_ram (
    .mclk(mclk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .enA(enA), .writeEnA(weA), .addrA(adA), .port_input_word_a(dA[31:0]),
    .port_input_parity_a(dA[35:32]), .port_sync_preset_a(preA),
    .output_stage_clock_enable_a(oceA), .chain_in_unregistered_a(clA),
    .chain_in_registered_a(crA), .dataOutA(qA), .port_output_parity_a(pA),
    .chain_out_unregistered_a(coLA), .chain_out_registered_a(coRA),
    .enB(enB), .writeEnB(weB), .addrB(adB), .port_input_word_b(dB[31:0]),
    .port_input_parity_b(dB[35:32]), .port_sync_preset_b(preB),
    .output_stage_clock_enable_b(oceB), .chain_in_unregistered_b(clB),
    .chain_in_registered_b(crB), .dataOutB(qB), .port_output_parity_b(pB),
    .chain_out_unregistered_b(coLB), .chain_out_registered_b(coRB));
  port_user_model partA (.mclk(mclk), .en(enA), .writeEn(weA), .addr(adA), .dataIn(dA),
    .preset(preA), .stageEn(oceA), .chainLat(clA), .chainReg(crA));
  port_user_model partB (.mclk(mclk), .en(enB), .writeEn(weB), .addr(adB), .dataIn(dB),
    .preset(preB), .stageEn(oceB), .chainLat(clB), .chainReg(crB));
  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // single word transfer; waits for hready in both phases
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // watchdog: the whole run needs well under 200 cycles
  initial begin
    #20000;
    err_count++;
    finish_test();
  end
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    // reset values and an unmapped place
    ahb(1'b0, `TDP_CFG_OFS, 32'h0);
    chk("cfg reset", {4'h0, rd}, 36'h0);
    chk("bus okay", {35'h0, hresp}, 36'h0);
    chk("bus ready", {35'h0, hreadyout}, 36'h1);
    ahb(1'b0, 32'h8, 32'h0);
    chk("unmapped", {4'h0, rd}, 36'h0);
    // write-through with parity as extra data
    partA.op(1'b1, 4'hF, 10'h5, 36'h511223344, 1'b0, 1'b0);
    chk("wt full", {pA, qA}, 36'h511223344);
    // one byte lane written, other lanes show stored bytes
    partA.op(1'b1, 4'h1, 10'h5, 36'hAAABBCCDD, 1'b0, 1'b0);
    chk("wt lane", {pA, qA}, 36'h4112233DD);
    // both ports read the same word in one edge
    fork
      partA.op(1'b1, 4'h0, 10'h5, 36'h0, 1'b0, 1'b0);
      partB.op(1'b1, 4'h0, 10'h5, 36'h0, 1'b0, 1'b0);
    join
    chk("dual rd A", {pA, qA}, 36'h4112233DD);
    chk("dual rd B", {pB, qB}, 36'h4112233DD);
    // disabled port neither writes nor moves its output
    partA.op(1'b0, 4'hF, 10'h5, 36'h0, 1'b0, 1'b0);
    chk("en low hold", {pA, qA}, 36'h4112233DD);
    partB.op(1'b1, 4'h0, 10'h5, 36'h0, 1'b0, 1'b0);
    chk("en low no wr", {pB, qB}, 36'h4112233DD);
    // read-first writer, other port reads the word in the same cycle
    ahb(1'b1, `TDP_CFG_OFS, 32'h1);
    fork
      partA.op(1'b1, 4'hF, 10'h5, 36'h355667788, 1'b0, 1'b0);
      partB.op(1'b1, 4'h0, 10'h5, 36'h0, 1'b0, 1'b0);
    join
    chk("rf writer", {pA, qA}, 36'h4112233DD);
    chk("rf reader", {pB, qB}, 36'h4112233DD);
    partB.op(1'b1, 4'h0, 10'h5, 36'h0, 1'b0, 1'b0);
    chk("rf stored", {pB, qB}, 36'h355667788);
    // hold mode: write leaves last read data standing
    ahb(1'b1, `TDP_CFG_OFS, 32'h2);
    partA.op(1'b1, 4'hF, 10'h7, 36'h0CAFE0001, 1'b0, 1'b0);
    chk("hold wr", {pA, qA}, 36'h4112233DD);
    // output register on B: stage enable held over the read, the word shows
    // one cycle later and then moves only with its enable
    ahb(1'b1, `TDP_CFG_OFS, 32'h20);
    partB.op(1'b1, 4'h0, 10'h7, 36'h0, 1'b1, 1'b0);
    chk("reg early", {pB, qB}, 36'h355667788);
    partB.op(1'b0, 4'h0, 10'h7, 36'h0, 1'b1, 1'b0);
    chk("reg late", {pB, qB}, 36'h0CAFE0001);
    chk("casc out reg", {35'h0, coRB}, 36'h1);
    partB.op(1'b1, 4'h0, 10'h5, 36'h0, 1'b0, 1'b0);
    partB.op(1'b0, 4'h0, 10'h5, 36'h0, 1'b0, 1'b0);
    chk("reg no ce", {pB, qB}, 36'h0CAFE0001);
    // presets in register and latch mode
    partB.op(1'b0, 4'h0, 10'h5, 36'h0, 1'b1, 1'b1);
    chk("preset reg", {pB, qB}, 36'h0);
    partA.op(1'b1, 4'h0, 10'h5, 36'h0, 1'b0, 1'b1);
    chk("preset lat", {pA, qA}, 36'h0);
    // cascade on A: chain input replaces bit 0, stage bit 0 goes out
    ahb(1'b1, `TDP_CFG_OFS, 32'h40);
    partA.chain(1'b1, 1'b0);
    partA.op(1'b1, 4'h0, 10'h5, 36'h0, 1'b0, 1'b0);
    chk("casc in", {35'h0, qA[0]}, 36'h1);
    chk("casc out", {35'h0, coLA}, 36'h0);
    // hazard flag from the read-first overlap, then cleared by a one
    ahb(1'b0, `TDP_STAT_OFS, 32'h0);
    chk("stat set", {4'h0, rd}, 36'h1);
    ahb(1'b1, `TDP_STAT_OFS, 32'h1);
    ahb(1'b0, `TDP_STAT_OFS, 32'h0);
    chk("stat clr", {4'h0, rd}, 36'h0);
    finish_test();
  end
endmodule
